// ---- logic/pacc_pkg.sv ----
// Package with register map, field layouts, reset values and timing constants.
//
// Contract
// R1 - PLL multiplier is nine-bit feedback value plus two, 2..513, reset gives 50.
// R2 - Feedback divisor register bits 15..9 ignore writes and read zero.
// R3 - RC trim code is six-bit two's complement, zero is centre frequency.
// R4 - Tuning register bits 15..6 read zero.
// R5 - Auxiliary PLL runs only while its enable bit 15 is one.
// R6 - Bit 14 reports auxiliary PLL lock, read only, writes ignored.
// R7 - Bit 13 picks auxiliary oscillator path when one, main VCO when zero; resets one.
// R8 - Auxiliary output divider codes 111..001 divide 1..64, code 000 divides 256.
// R9 - Bit 7 selects primary oscillator as auxiliary source, else no clock.
// R10 - Bit 6 feeds the RC oscillator to auxiliary PLL, else bit 7 decides.
// R11 - Reference clock reaches its pin only while output enable bit 15 is one.
// R12 - In sleep the reference output runs only if run-in-sleep bit 13 is one.
// R13 - Bit 12 selects crystal when one, system clock when zero, as reference input.
// R14 - Reference divider divides by two to the four-bit code, up to 32768.
// R15 - Software clears output enable before changing the reference divider.
// R16 - Auxiliary PLL multiplies its input by a fixed sixteen.
// R17 - Writable fields take power-on values at reset; unimplemented bits read zero.
package pacc_pkg;
   localparam logic [3:0]  ADDR_PLL_FBD   = 4'h0;
   localparam logic [3:0]  ADDR_FRC_TUN   = 4'h4;
   localparam logic [3:0]  ADDR_AUX_CTL   = 4'h8;
   localparam logic [3:0]  ADDR_REF_CTL   = 4'hC;
   localparam logic [15:0] PLL_FBD_MASK   = 16'h01FF;
   localparam logic [15:0] FRC_TUN_MASK   = 16'h003F;
   localparam logic [15:0] AUX_CTL_WMASK  = 16'hA7C0;
   localparam logic [15:0] REF_CTL_MASK   = 16'hBF00;
   localparam logic [8:0]  PLL_FBD_RESET  = 9'h030;
   localparam logic [5:0]  FRC_TUN_RESET  = 6'h00;
   localparam logic [15:0] AUX_CTL_RESET  = 16'h2700;
   localparam logic [15:0] REF_CTL_RESET  = 16'h0000;
   localparam logic [9:0]  PLL_MULT_OFFS  = 10'h002;
   localparam logic [4:0]  AUX_PLL_FACTOR = 5'h10;
   localparam int AUX_EN_BIT   = 15;
   localparam int AUX_LOCK_BIT = 14;
   localparam int AUX_SEL_BIT  = 13;
   localparam int AUX_DIV_LSB  = 8;
   localparam int AUX_REF_BIT  = 7;
   localparam int AUX_RC_BIT   = 6;
   localparam int REF_EN_BIT   = 15;
   localparam int REF_SLP_BIT  = 13;
   localparam int REF_SRC_BIT  = 12;
   localparam int REF_DIV_LSB  = 8;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Auxiliary PLL lock delay.
   localparam int AUX_LOCK_NS  = 400;
   localparam int CLK_PERIOD_NS = 40;
   localparam int AUX_LOCK_CYC = (AUX_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Auxiliary clock source routing.
   typedef enum logic [1:0] {AUX_SRC_NONE, AUX_SRC_POSC, AUX_SRC_FRC} pacc_aux_src_t;
endpackage

// ---- logic/pacc_div_if.sv ----
// Interface carrying a clock-enable divider request and its output.
`timescale 1ns/1ps
interface pacc_div_if;
   logic        run;
   logic        tick;
   logic [15:0] ratio_m1;
   logic        out_pulse;
   modport ctl (output run, output tick, output ratio_m1, input out_pulse);
   modport div (input run, input tick, input ratio_m1, output out_pulse);
endinterface

// ---- logic/pacc_divider.sv ----
// Enable-pulse divider: emits one pulse per ratio input ticks.
`timescale 1ns/1ps
module pacc_divider (
   // Clock and reset.
   input  wire logic sys_clk_in,
   input  wire logic reset_in,
   // Control.
   pacc_div_if.div   dv
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        pulse;
   } pacc_div_st_t;
   pacc_div_st_t s_r;
   pacc_div_st_t s_nxt;
   always_comb begin
      s_nxt       = s_r;
      s_nxt.pulse = 1'b0;
      if (!dv.run) begin
         s_nxt.cnt = 16'h0000;
      end else if (dv.tick) begin
         if (s_r.cnt >= dv.ratio_m1) begin
            s_nxt.cnt   = 16'h0000;
            s_nxt.pulse = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
         end
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign dv.out_pulse = s_r.pulse;
endmodule

// ---- logic/pacc_top.sv ----
// Clock configuration registers with auxiliary and reference clock enable paths.
`timescale 1ns/1ps
module pacc_top #(
   parameter int LOCK_CYC = pacc_pkg::AUX_LOCK_CYC
) (
   // Clock and reset.
   input  wire logic        sys_clk_in,
   input  wire logic        reset_in,
   // AXI4-Lite write address and data.
   input  wire logic [3:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   // AXI4-Lite write response.
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   // AXI4-Lite read.
   input  wire logic [3:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   // Clock source ticks, one-cycle enables, and the sleep level.
   input  wire logic        posc_tick_in,
   input  wire logic        frc_tick_in,
   input  wire logic        main_pll_vco_output_tick_in,
   input  wire logic        sleep_in,
   // Configuration outputs, auxiliary clock tick and reference clock pin.
   output logic [9:0]       pll_mult_factor_out,
   output logic [5:0]       frc_trim_code_out,
   output logic             aux_pll_running_out,
   output logic [1:0]       aux_pll_src_out,
   output logic [4:0]       aux_pll_factor_out,
   output logic             aux_clk_tick_out,
   output logic             ref_clock_pin_out
);
   // The lock counter is sixteen bits wide and must count at least once.
   if (LOCK_CYC < 1 || LOCK_CYC > 65535) begin : g_bad_lock
      $error("LOCK_CYC out of range");
   end

   typedef struct packed {
      logic        aw_got;
      logic [3:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [8:0]  pll_fbd;
      logic [5:0]  frc_tun;
      logic [15:0] aux_ctl;
      logic [15:0] ref_ctl;
      logic [15:0] lock_cnt;
      logic        locked;
      logic        ref_pin;
   } pacc_st_t;

   pacc_st_t s_r;
   pacc_st_t s_nxt;

   pacc_div_if aux_dv ();
   pacc_div_if ref_dv ();

   pacc_divider u_aux_div (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .dv         (aux_dv.div)
   );
   pacc_divider u_ref_div (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .dv         (ref_dv.div)
   );

   logic          aux_pll_on;
   logic          aux_pll_in_tick;
   logic          aux_src_tick;
   logic [2:0]    aux_code;
   logic [3:0]    ref_code;
   logic          ref_run;
   pacc_pkg::pacc_aux_src_t aux_src;

   always_comb begin
      aux_pll_on = s_r.aux_ctl[pacc_pkg::AUX_EN_BIT]; // R5
      if (s_r.aux_ctl[pacc_pkg::AUX_RC_BIT]) begin
         aux_src = pacc_pkg::AUX_SRC_FRC; // R10
      end else if (s_r.aux_ctl[pacc_pkg::AUX_REF_BIT]) begin
         aux_src = pacc_pkg::AUX_SRC_POSC; // R9
      end else begin
         aux_src = pacc_pkg::AUX_SRC_NONE; // R9
      end
      unique case (aux_src)
         pacc_pkg::AUX_SRC_FRC:  aux_pll_in_tick = frc_tick_in;
         pacc_pkg::AUX_SRC_POSC: aux_pll_in_tick = posc_tick_in;
         pacc_pkg::AUX_SRC_NONE: aux_pll_in_tick = 1'b0;
      endcase
      // The PLL output is modelled by its input tick once locked.
      if (s_r.aux_ctl[pacc_pkg::AUX_SEL_BIT]) begin
         aux_src_tick = aux_pll_on && s_r.locked && aux_pll_in_tick; // R7
      end else begin
         aux_src_tick = main_pll_vco_output_tick_in; // R7
      end
      aux_code = s_r.aux_ctl[pacc_pkg::AUX_DIV_LSB +: 3];
      ref_code = s_r.ref_ctl[pacc_pkg::REF_DIV_LSB +: 4];
      ref_run  = s_r.ref_ctl[pacc_pkg::REF_EN_BIT]
                 && (!sleep_in || s_r.ref_ctl[pacc_pkg::REF_SLP_BIT]); // R11 R12
   end

   always_comb begin
      aux_dv.run  = 1'b1;
      aux_dv.tick = aux_src_tick;
      if (aux_code == 3'b000) begin
         aux_dv.ratio_m1 = 16'h00FF; // R8
      end else begin
         aux_dv.ratio_m1 = 16'((16'h0001 << (3'd7 - aux_code)) - 16'h0001); // R8
      end
      ref_dv.run  = ref_run;
      ref_dv.tick = s_r.ref_ctl[pacc_pkg::REF_SRC_BIT] ? posc_tick_in : 1'b1; // R13
      // Two output pulses make one pin period, so the pin toggles every 2^(n-1) ticks.
      ref_dv.ratio_m1 = (ref_code == 4'h0) ? 16'h0000
                        : 16'((16'h0001 << (ref_code - 4'h1)) - 16'h0001); // R14
   end

   logic        wr_fire;
   logic        rd_fire;
   logic [15:0] wd;

   assign wd = s_r.w_data[15:0];

   assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
   assign rd_fire = s_axi_arvalid_in && !s_r.rvalid;

   always_comb begin
      logic [15:0] ctl;
      logic [15:0] rsel;
      ctl   = 16'h0000;
      rsel  = 16'h0000;
      s_nxt = s_r;
      if (s_axi_awvalid_in && !s_r.aw_got) begin
         s_nxt.aw_got  = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !s_r.w_got) begin
         s_nxt.w_got  = 1'b1;
         s_nxt.w_data = s_axi_wdata_in;
         s_nxt.w_strb = s_axi_wstrb_in;
      end
      if (wr_fire) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = pacc_pkg::RESP_OKAY;
         if (s_r.aw_addr[1:0] != 2'b00) begin
            s_nxt.bresp = pacc_pkg::RESP_SLVERR;
         end else begin
            unique case (s_r.aw_addr)
               pacc_pkg::ADDR_PLL_FBD: begin
                  if (s_r.w_strb[0]) s_nxt.pll_fbd[7:0] = wd[7:0]; // R1
                  if (s_r.w_strb[1]) s_nxt.pll_fbd[8] = wd[8]; // R2
               end
               pacc_pkg::ADDR_FRC_TUN: begin
                  if (s_r.w_strb[0]) s_nxt.frc_tun = wd[5:0]; // R3 R4
               end
               pacc_pkg::ADDR_AUX_CTL: begin
                  ctl = s_r.aux_ctl;
                  if (s_r.w_strb[0]) ctl[7:0] = wd[7:0];
                  if (s_r.w_strb[1]) ctl[15:8] = wd[15:8];
                  s_nxt.aux_ctl = (ctl & pacc_pkg::AUX_CTL_WMASK)
                                  | (s_r.aux_ctl & ~pacc_pkg::AUX_CTL_WMASK); // R6 R17
               end
               pacc_pkg::ADDR_REF_CTL: begin
                  ctl = s_r.ref_ctl;
                  if (s_r.w_strb[1]) ctl[15:8] = wd[15:8];
                  // Divider changes are honoured as written; software keeps the order.
                  s_nxt.ref_ctl = ctl & pacc_pkg::REF_CTL_MASK; // R15 R17
               end
               default: s_nxt.bresp = pacc_pkg::RESP_SLVERR;
            endcase
         end
      end
      if (s_r.bvalid && s_axi_bready_in) begin
         s_nxt.bvalid = 1'b0;
      end
      if (rd_fire) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = pacc_pkg::RESP_OKAY;
         unique case (s_axi_araddr_in)
            pacc_pkg::ADDR_PLL_FBD: rsel = {7'h00, s_r.pll_fbd}; // R2
            pacc_pkg::ADDR_FRC_TUN: rsel = {10'h000, s_r.frc_tun}; // R4
            pacc_pkg::ADDR_AUX_CTL: rsel = s_r.aux_ctl;
            pacc_pkg::ADDR_REF_CTL: rsel = s_r.ref_ctl;
            default:                s_nxt.rresp = pacc_pkg::RESP_SLVERR;
         endcase
         s_nxt.rdata = {16'h0000, rsel};
      end else if (s_r.rvalid && s_axi_rready_in) begin
         s_nxt.rvalid = 1'b0;
      end
      // Lock follows enable with a source selected after the lock delay and drops one cycle after the enable bit clears or the source goes to none.
      if (!aux_pll_on || aux_src == pacc_pkg::AUX_SRC_NONE) begin
         s_nxt.lock_cnt = 16'h0000;
         s_nxt.locked   = 1'b0; // R6
      end else if (s_r.lock_cnt >= 16'(LOCK_CYC - 1)) begin
         s_nxt.locked = 1'b1; // R6
      end else begin
         s_nxt.lock_cnt = s_r.lock_cnt + 16'h0001;
      end
      s_nxt.aux_ctl[pacc_pkg::AUX_LOCK_BIT] = s_nxt.locked; // R6
      if (!ref_run) begin
         s_nxt.ref_pin = 1'b0; // R11 R12
      end else if (ref_code == 4'h0) begin
         // Code zero passes the source ticks to the pin undivided, so a source
         // that ticks every cycle shows as a steady high level.
         s_nxt.ref_pin = ref_dv.tick; // R14
      end else if (ref_dv.out_pulse) begin
         s_nxt.ref_pin = !s_r.ref_pin; // R14
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         s_r         <= '0;
         s_r.pll_fbd <= pacc_pkg::PLL_FBD_RESET; // R1 R17
         s_r.frc_tun <= pacc_pkg::FRC_TUN_RESET; // R17
         s_r.aux_ctl <= pacc_pkg::AUX_CTL_RESET; // R7 R17
         s_r.ref_ctl <= pacc_pkg::REF_CTL_RESET; // R17
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready_out  = !s_r.aw_got;
   assign s_axi_wready_out   = !s_r.w_got;
   assign s_axi_bvalid_out   = s_r.bvalid;
   assign s_axi_bresp_out    = s_r.bresp;
   assign s_axi_arready_out  = !s_r.rvalid;
   assign s_axi_rvalid_out   = s_r.rvalid;
   assign s_axi_rdata_out    = s_r.rdata;
   assign s_axi_rresp_out    = s_r.rresp;
   assign pll_mult_factor_out = {1'b0, s_r.pll_fbd} + pacc_pkg::PLL_MULT_OFFS; // R1
   assign frc_trim_code_out  = s_r.frc_tun; // R3
   assign aux_pll_running_out = aux_pll_on; // R5
   assign aux_pll_src_out    = aux_src;
   assign aux_pll_factor_out = pacc_pkg::AUX_PLL_FACTOR; // R16
   assign aux_clk_tick_out   = aux_dv.out_pulse;
   assign ref_clock_pin_out  = s_r.ref_pin;

   chk_lock_needs_enable: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !s_r.aux_ctl[pacc_pkg::AUX_EN_BIT] |=> !s_r.aux_ctl[pacc_pkg::AUX_LOCK_BIT])
      else $error("lock shown while PLL disabled"); // R6
   chk_fbd_upper_zero: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_r.rvalid && $past(s_axi_araddr_in) == pacc_pkg::ADDR_PLL_FBD && $rose(s_r.rvalid)
      |-> s_r.rdata[31:9] == 23'h000000)
      else $error("feedback divisor upper bits nonzero"); // R2
   chk_tun_upper_zero: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(s_r.rvalid) && $past(s_axi_araddr_in) == pacc_pkg::ADDR_FRC_TUN
      |-> s_r.rdata[31:6] == 26'h0000000)
      else $error("tuning upper bits nonzero"); // R4
   chk_mult_offset: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      pll_mult_factor_out == {1'b0, s_r.pll_fbd} + 10'h002)
      else $error("multiplier not divisor plus two"); // R1
   chk_ref_pin_off: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !s_r.ref_ctl[pacc_pkg::REF_EN_BIT] |=> !ref_clock_pin_out)
      else $error("reference pin active while disabled"); // R11
   chk_ref_sleep_stop: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      sleep_in && !s_r.ref_ctl[pacc_pkg::REF_SLP_BIT] |=> !ref_clock_pin_out)
      else $error("reference pin runs in sleep"); // R12
   chk_aux_no_src: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !s_r.aux_ctl[pacc_pkg::AUX_RC_BIT] && !s_r.aux_ctl[pacc_pkg::AUX_REF_BIT]
      |-> aux_pll_src_out == 2'(pacc_pkg::AUX_SRC_NONE))
      else $error("source chosen with no input selected"); // R9
   chk_aux_rc_src: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_r.aux_ctl[pacc_pkg::AUX_RC_BIT] |-> aux_pll_src_out == 2'(pacc_pkg::AUX_SRC_FRC))
      else $error("RC select not honoured"); // R10
   chk_aux_reset_val: assert property (@(posedge sys_clk_in)
      $past(reset_in) |-> s_r.aux_ctl == 16'h2700 && s_r.pll_fbd == 9'h030)
      else $error("reset values wrong"); // R17
   chk_aux_div256: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      aux_code == 3'b000 |-> aux_dv.ratio_m1 == 16'h00FF)
      else $error("code zero not divide by 256"); // R8
endmodule

// ---- testbench/tb_pacc_top.sv ----
// Self-checking bench for the clock configuration register block.
`timescale 1ns/1ps
module tb_pacc_top;
   localparam int LOCK_N = 2;
   logic        sys_clk_in = 1'b0;
   logic        reset_in   = 1'b1;
   logic        posc_tick  = 1'b0;
   logic        frc_tick   = 1'b0;
   logic        vco_tick   = 1'b0;
   logic        sleep      = 1'b0;
   logic        posc_alt   = 1'b0;
   logic [3:0]  awaddr     = 4'h0;
   logic        awvalid    = 1'b0;
   logic [31:0] wdata      = 32'h0000_0000;
   logic [3:0]  wstrb      = 4'hF;
   logic        wvalid     = 1'b0;
   logic        bready     = 1'b0;
   logic [3:0]  araddr     = 4'h0;
   logic        arvalid    = 1'b0;
   logic        rready     = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid, running, aux_tick, ref_pin;
   wire  [1:0]  bresp, rresp, src;
   wire  [31:0] rdata;
   wire  [9:0]  mult;
   wire  [5:0]  trim;
   wire  [4:0]  factor;
   int          n_fail     = 0;
   int          compares   = 0;

   always #20 sys_clk_in = ~sys_clk_in;

   // Source ticks: the oscillator ticks every cycle or every other cycle.
   always @(posedge sys_clk_in) begin
      posc_tick <= posc_alt ? !posc_tick : 1'b1;
      frc_tick  <= 1'($urandom_range(1));
      vco_tick  <= 1'b1;
   end

   pacc_top #(.LOCK_CYC(LOCK_N)) pacc_top_i (
      .sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .posc_tick_in(posc_tick), .frc_tick_in(frc_tick),
      .main_pll_vco_output_tick_in(vco_tick), .sleep_in(sleep),
      .pll_mult_factor_out(mult), .frc_trim_code_out(trim), .aux_pll_running_out(running),
      .aux_pll_src_out(src), .aux_pll_factor_out(factor), .aux_clk_tick_out(aux_tick),
      .ref_clock_pin_out(ref_pin));

   task automatic end_of_test();
      $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic hang();
      n_fail++;
      $display("Wait limit used up at %0t", $time);
      end_of_test();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask

   // Handshakes are judged at the falling edge, where ready and valid are settled.
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int   n;
      logic ta, tw, tb;
      n = 0;
      tb = 1'b0;
      @(posedge sys_clk_in);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!tb) begin
         @(negedge sys_clk_in);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         r  = bresp;
         @(posedge sys_clk_in);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
         n++;
         if (n > 50) hang();
      end
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int   n;
      logic ta, tb;
      n = 0;
      tb = 1'b0;
      @(posedge sys_clk_in);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!tb) begin
         @(negedge sys_clk_in);
         ta = arvalid && arready;
         tb = rvalid;
         d  = rdata;
         r  = rresp;
         @(posedge sys_clk_in);
         if (ta) arvalid <= 1'b0;
         if (tb) rready <= 1'b0;
         n++;
         if (n > 50) hang();
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk(32'(r), 32'(pacc_pkg::RESP_OKAY));
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      chk(32'(r), 32'(pacc_pkg::RESP_OKAY));
      chk(d, e);
   endtask

   // Cycles between two aux pulses, or between two changes of the reference pin.
   task automatic gap(input bit pin, output int c);
      int   n;
      logic p, v;
      n = 0;
      @(negedge sys_clk_in);
      p = ref_pin;
      for (int e = 0; e < 2; e++) begin
         c = 0;
         do begin
            @(negedge sys_clk_in);
            v = pin ? ref_pin : aux_tick;
            c++;
            n++;
         end while (!(pin ? v !== p : v === 1'b1) && n < 70000);
         p = v;
      end
      if (n >= 70000) hang();
   endtask

   task automatic quiet(input bit pin, input int cyc, output int k);
      logic p;
      p = ref_pin;
      k = 0;
      repeat (cyc) begin
         @(negedge sys_clk_in);
         if (pin ? ref_pin !== p : aux_tick !== 1'b0) k++;
         p = ref_pin;
      end
   endtask

   function automatic int aux_div(input logic [2:0] code);
      return (code == 3'h0) ? 256 : (1 << (7 - code));
   endfunction

   function automatic int ref_gap(input logic [3:0] code);
      return (code == 4'h0) ? 1 : (1 << (code - 1));
   endfunction

   function automatic logic [31:0] rb(input logic [3:0] a, input logic [31:0] d);
      case (a)
         4'h0: return d & 32'h0000_01FF;
         4'h4: return d & 32'h0000_003F;
         4'h8: return d & 32'h0000_27C0;
         default: return d & 32'h0000_BF00;
      endcase
   endfunction

   task automatic reset_vals();
      rd(4'h0, 32'h0000_0030);
      rd(4'h4, 32'h0000_0000);
      rd(4'h8, 32'h0000_2700);
      rd(4'hC, 32'h0000_0000);
      @(negedge sys_clk_in);
      chk(32'(mult), 32'h0000_0032);
      chk(32'(running), 32'h0000_0000);
      chk(32'(ref_pin), 32'h0000_0000);
      $display("reset values done");
   endtask

   initial begin
      logic [31:0] d;
      logic [31:0] cdat [5];
      logic [3:0]  codes [6];
      logic [3:0]  a;
      logic [1:0]  r;
      int          c;
      int          k;
      void'($urandom(34425));
      cdat = '{32'h0000_FFFF, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0020, 32'h0000_001F};
      codes = '{4'h7, 4'h1, 4'h2, 4'h3, 4'h4, 4'hF};
      repeat (12) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      reset_vals();
      for (int i = 0; i < 24; i++) begin
         a = (i < 2) ? 4'h0 : (i < 5) ? 4'h4 : 4'(4 * (i % 4));
         d = (i < 5) ? cdat[i] : ($urandom() & 32'hFFFF_7FFF);
         wr(a, d);
         rd(a, rb(a, d));
         @(negedge sys_clk_in);
         if (a == 4'h0) chk(32'(mult), 32'(d[8:0]) + 32'h0000_0002);
         if (a == 4'h4) chk(32'(trim), 32'(d[5:0]));
      end
      $display("register access done");
      wr(4'h0, 32'h0000_0055);
      for (int i = 0; i < 16; i++) begin
         a = 4'(i);
         if (a[1:0] != 2'b00) begin
            axi_wr(a, 32'hFFFF_FFFF, r);
            chk(32'(r), 32'(pacc_pkg::RESP_SLVERR));
            axi_rd(a, d, r);
            chk(32'(r), 32'(pacc_pkg::RESP_SLVERR));
            chk(d, 32'h0000_0000);
         end
      end
      rd(4'h0, 32'h0000_0055);
      wstrb <= 4'h2;
      wr(4'h0, 32'h0000_01AA);
      wstrb <= 4'hF;
      rd(4'h0, 32'h0000_0155);
      $display("unmapped access done");
      wr(4'h8, 32'h0000_A780);
      repeat (LOCK_N + 4) @(posedge sys_clk_in);
      rd(4'h8, 32'h0000_E780);
      @(negedge sys_clk_in);
      chk(32'(running), 32'h0000_0001);
      chk(32'(src), 32'h0000_0001);
      chk(32'(factor), 32'h0000_0010);
      gap(1'b0, c);
      chk(32'(c), 32'h0000_0001);
      posc_alt <= 1'b1;
      gap(1'b0, c);
      chk(32'(c), 32'h0000_0002);
      wr(4'h8, 32'h0000_67C0);
      rd(4'h8, 32'h0000_27C0);
      chk(32'(running), 32'h0000_0000);
      chk(32'(src), 32'h0000_0002);
      quiet(1'b0, 300, k);
      chk(32'(k), 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
         wr(4'h8, {21'h00_0000, 3'(i), 8'h00});
         @(negedge sys_clk_in);
         chk(32'(src), 32'h0000_0000);
         gap(1'b0, c);
         chk(32'(c), 32'(aux_div(3'(i))));
      end
      $display("auxiliary clock done");
      foreach (codes[j]) begin
         wr(4'hC, {20'h0_0000, codes[j], 8'h00});
         repeat (3) @(negedge sys_clk_in);
         quiet(1'b1, 20, k);
         chk(32'(k), 32'h0000_0000);
         chk(32'(ref_pin), 32'h0000_0000);
         wr(4'hC, {16'h0000, 4'h8, codes[j], 8'h00});
         gap(1'b1, c);
         chk(32'(c), 32'(ref_gap(codes[j])));
         wr(4'hC, {20'h0_0000, codes[j], 8'h00});
      end
      wr(4'hC, 32'h0000_1100);
      wr(4'hC, 32'h0000_9100);
      gap(1'b1, c);
      chk(32'(c), 32'h0000_0002);
      wr(4'hC, 32'h0000_1100);
      wr(4'hC, 32'h0000_1000);
      wr(4'hC, 32'h0000_9000);
      gap(1'b1, c);
      chk(32'(c), 32'h0000_0001);
      wr(4'hC, 32'h0000_0000);
      wr(4'hC, 32'h0000_8000);
      sleep <= 1'b1;
      repeat (3) @(negedge sys_clk_in);
      quiet(1'b1, 100, k);
      chk(32'(k), 32'h0000_0000);
      chk(32'(ref_pin), 32'h0000_0000);
      wr(4'hC, 32'h0000_2000);
      wr(4'hC, 32'h0000_2100);
      wr(4'hC, 32'h0000_A100);
      gap(1'b1, c);
      chk(32'(c), 32'h0000_0001);
      sleep <= 1'b0;
      $display("reference clock done");
      @(posedge sys_clk_in);
      reset_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      reset_vals();
      end_of_test();
   end
endmodule
